/* File: ccpc_pkg.sv */
`default_nettype none
package ccpc_pkg;
  localparam logic [15:0] CLOCK_CONTROL_ADDR  = 16'h4000;
  localparam logic [15:0] PLL_SETTINGS_ADDR   = 16'h4002;
  localparam logic [15:0] PLL_LAST_ADDR       = 16'h4007;
  localparam logic [15:0] CONV_CONTROL_ADDR   = 16'h4017;
  localparam logic [15:0] POWER_ZERO_ADDR     = 16'h4080;
  localparam logic [15:0] POWER_ONE_ADDR      = 16'h4081;
  localparam logic [15:0] ENGINE_RATE_ADDR    = 16'h40EB;
  localparam logic [15:0] SERIAL_RATE_ADDR    = 16'h40F8;
  localparam logic [2:0]  PLL_LAST_IDX        = 3'h5;
  localparam int CLK_EN_BIT      = 0;
  localparam int CLK_RATE_LSB    = 1;
  localparam int CLK_SRC_BIT     = 3;
  localparam int PWR0_ENGINE_BIT = 0;
  localparam int PWR0_MEMCTL_BIT = 6;
  localparam int PWR1_ADC_BIT    = 0;
  localparam int PWR1_DAC_BIT    = 1;
  localparam int CONV_ADC_OSR    = 4;
  localparam int CONV_DAC_OSR    = 5;
  localparam int PLL_M_LSB       = 0;
  localparam int PLL_N_LSB       = 16;
  localparam int PLL_FRAC_BIT    = 32;
  localparam int PLL_X_LSB       = 33;
  localparam int PLL_R_LSB       = 35;
  localparam int PLL_EN_BIT      = 40;
  localparam int PLL_LOCK_BIT    = 41;
  localparam int PLL_TOP_LSB     = 40;
  localparam logic [7:0]  CLOCK_CONTROL_MASK = 8'h0F;
  localparam logic [7:0]  CONV_CONTROL_MASK  = 8'h37;
  localparam logic [7:0]  POWER_ONE_MASK     = 8'h03;
  localparam logic [7:0]  ENGINE_RATE_MASK   = 8'h0F;
  localparam logic [7:0]  SERIAL_RATE_MASK   = 8'h07;
  localparam logic [7:0]  PLL_TOP_MASK       = 8'h01;
  localparam logic [7:0]  REG_RESET          = 8'h00;
  localparam logic [47:0] PLL_RESET          = 48'h0;
  localparam logic [1:0]  RATE_1024FS        = 2'h3;
  localparam logic [23:0] CORE_DIV_PLL       = 24'h4;
  localparam logic [11:0] CORE_FS_MULT       = 12'h100;
  localparam int CLK_MHZ      = 125;
  localparam int LOCK_TIME_US = 3000;
  localparam int LOCK_CYCLES  = LOCK_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {HS_IDLE, HS_SINGLE, HS_BURST} ccpc_host_state_t;
endpackage
`default_nettype wire

/* File: ccpc_cp_if.sv */
`default_nettype none
interface ccpc_cp_if;
  logic        valid;
  logic        write;
  logic        burst;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        ack;
  logic [7:0]  rdata;
  logic        err;
  logic        power_down_pin_n;
  modport device (input valid, input write, input burst, input addr, input wdata,
                  input power_down_pin_n, output ack, output rdata, output err);
  modport host (output valid, output write, output burst, output addr, output wdata,
                output power_down_pin_n, input ack, input rdata, input err);
endinterface
`default_nettype wire

/* File: ccpc_device.sv */
// Notes on behaviour
// - memory and engine power before engine access
// - filter oversampling 64 or 128, 128 default
// - power-down pin high stops the device
// - pin low again reinitializes to reset state
// - core clock always 256 times base rate
// - rate field picks direct divide 1 to 4
// - PLL source forces core divide by four
// - source bit: master clock or PLL
// - core clock enable gates all clocks
// - converter rate field scales base rate
// - engine and serial rates own fields
// - host should program equal rates everywhere
// - host writes six PLL bytes in one burst
// - integer mode multiplies by R only
// - PLL reference between 11 and 20 MHz
// - all rate clocks derive from core clock
// - converters and PLL individually switchable off
// - during lock with PLL source only clock registers accessible
// - fractional mode multiplies by R plus N/M
`default_nettype none
module ccpc_device
  import ccpc_pkg::*;
#(
  parameter int LOCK_CYCLES_P = LOCK_CYCLES
) (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  ccpc_cp_if.device   cp,
  output logic        core_tick_o,
  output logic        conv_fs_o,
  output logic        serial_fs_o,
  output logic        engine_fs_o,
  output logic        adc_osr64_o,
  output logic        dac_osr64_o,
  output logic        adc_on_o,
  output logic        dac_on_o,
  output logic        pll_on_o,
  output logic        pll_locked_o,
  output logic        memctl_on_o,
  output logic        engine_on_o,
  output logic        powered_down_o
);
  function automatic logic [11:0] rate_period(input logic [3:0] code);
    unique case (code)
      4'h1:    rate_period = CORE_FS_MULT * 12'h6;
      4'h2:    rate_period = CORE_FS_MULT * 12'h4;
      4'h3:    rate_period = CORE_FS_MULT * 12'h3;
      4'h4:    rate_period = CORE_FS_MULT * 12'h2;
      4'h5:    rate_period = CORE_FS_MULT + (CORE_FS_MULT >> 1);
      4'h6:    rate_period = CORE_FS_MULT >> 1;
      default: rate_period = CORE_FS_MULT;
    endcase
  endfunction

  logic        pdn_meta;
  logic        pdn_sync;
  logic        run_rst;
  logic [7:0]  clock_control;
  logic [7:0]  converter_control_zero;
  logic [7:0]  digital_power_enable_zero;
  logic [7:0]  digital_power_enable_one;
  logic [7:0]  engine_frame_rate;
  logic [7:0]  serial_port_rate;
  logic [47:0] pll_settings;
  logic [39:0] pll_stage;
  logic [2:0]  stage_idx;
  logic [31:0] lock_cnt;
  logic        pll_locked;
  logic        ack_q;
  logic        take;
  logic        in_pll;
  logic        is_setup;
  logic        clock_ok;
  logic        refused;
  logic        wr_ok;
  logic        pll_commit;
  logic [2:0]  pll_idx;
  logic [47:0] pll_view;
  logic [7:0]  rd_data;

  // pin high means powered down; registers go back to reset values
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pdn_meta <= 1'b0;
      pdn_sync <= 1'b0;
    end else begin
      pdn_meta <= cp.power_down_pin_n;
      pdn_sync <= pdn_meta;
    end
  end
  assign run_rst = !rst_n_i || pdn_sync;

  assign take     = cp.valid && !ack_q;
  assign in_pll   = (cp.addr >= PLL_SETTINGS_ADDR) && (cp.addr <= PLL_LAST_ADDR);
  assign pll_idx  = 3'(cp.addr - PLL_SETTINGS_ADDR);
  assign is_setup = (cp.addr == CLOCK_CONTROL_ADDR) || in_pll;
  assign clock_ok = clock_control[CLK_EN_BIT] && (!clock_control[CLK_SRC_BIT] || pll_locked);
  always_comb begin
    refused = !is_setup && !clock_ok;
    if ((cp.addr == ENGINE_RATE_ADDR) || (cp.addr == SERIAL_RATE_ADDR)) begin
      if (!(digital_power_enable_zero[PWR0_MEMCTL_BIT] && digital_power_enable_zero[PWR0_ENGINE_BIT])) begin
        refused = 1'b1;
      end
    end
  end
  assign wr_ok      = take && cp.write && !refused;
  assign pll_commit = wr_ok && in_pll && cp.burst && (pll_idx == stage_idx) && (pll_idx == PLL_LAST_IDX);

  assign pll_view = {pll_settings[47:PLL_LOCK_BIT+1], pll_locked, pll_settings[PLL_LOCK_BIT-1:0]};
  always_comb begin
    rd_data = 8'h00;
    if (in_pll) begin
      rd_data = pll_view[{pll_idx, 3'b000} +: 8];
    end else begin
      unique case (cp.addr)
        CLOCK_CONTROL_ADDR: rd_data = clock_control;
        CONV_CONTROL_ADDR:  rd_data = converter_control_zero;
        POWER_ZERO_ADDR:    rd_data = digital_power_enable_zero;
        POWER_ONE_ADDR:     rd_data = digital_power_enable_one;
        ENGINE_RATE_ADDR:   rd_data = engine_frame_rate;
        SERIAL_RATE_ADDR:   rd_data = serial_port_rate;
        default:            rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (run_rst) begin
      ack_q    <= 1'b0;
      cp.rdata <= 8'h00;
      cp.err   <= 1'b0;
    end else begin
      ack_q    <= take;
      cp.rdata <= (take && !cp.write && !refused) ? rd_data : 8'h00;
      cp.err   <= take && refused;
    end
  end
  assign cp.ack = ack_q;

  always_ff @(posedge clk_i) begin
    if (run_rst) begin
      clock_control             <= REG_RESET;
      converter_control_zero    <= REG_RESET;
      digital_power_enable_zero <= REG_RESET;
      digital_power_enable_one  <= REG_RESET;
      engine_frame_rate         <= REG_RESET;
      serial_port_rate          <= REG_RESET;
    end else if (wr_ok) begin
      unique case (cp.addr)
        CLOCK_CONTROL_ADDR: clock_control             <= cp.wdata & CLOCK_CONTROL_MASK;
        CONV_CONTROL_ADDR:  converter_control_zero    <= cp.wdata & CONV_CONTROL_MASK;
        POWER_ZERO_ADDR:    digital_power_enable_zero <= cp.wdata;
        POWER_ONE_ADDR:     digital_power_enable_one  <= cp.wdata & POWER_ONE_MASK;
        ENGINE_RATE_ADDR:   engine_frame_rate         <= cp.wdata & ENGINE_RATE_MASK;
        SERIAL_RATE_ADDR:   serial_port_rate          <= cp.wdata & SERIAL_RATE_MASK;
        default: ;
      endcase
    end
  end

  // pll bytes are staged and only land when the sixth arrives in one burst
  always_ff @(posedge clk_i) begin
    if (run_rst) begin
      pll_settings <= PLL_RESET;
      pll_stage    <= 40'h0;
      stage_idx    <= 3'h0;
    end else if (take) begin
      stage_idx <= 3'h0;
      if (wr_ok && in_pll && cp.burst && (pll_idx == stage_idx)) begin
        if (pll_commit) begin
          pll_settings <= {cp.wdata & PLL_TOP_MASK, pll_stage};
        end else begin
          pll_stage[{pll_idx, 3'b000} +: 8] <= cp.wdata;
          stage_idx <= stage_idx + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (run_rst || pll_commit || !pll_settings[PLL_EN_BIT]) begin
      lock_cnt   <= 32'h0;
      pll_locked <= 1'b0;
    end else if (!pll_locked) begin
      if (lock_cnt >= 32'(LOCK_CYCLES_P - 1)) begin
        pll_locked <= 1'b1;
      end else begin
        lock_cnt <= lock_cnt + 32'h1;
      end
    end
  end

  // clock settings are taken only at a divider wrap so no runt tick escapes
  logic [1:0] div_cnt;
  logic [1:0] active_rate;
  logic       active_src;
  logic       active_en;
  logic [1:0] eff_rate;
  assign eff_rate = clock_control[CLK_SRC_BIT] ? RATE_1024FS : clock_control[CLK_RATE_LSB +: 2];
  always_ff @(posedge clk_i) begin
    if (run_rst) begin
      div_cnt     <= 2'h0;
      active_rate <= 2'h0;
      active_src  <= 1'b0;
      active_en   <= 1'b0;
    end else if (div_cnt == active_rate) begin
      div_cnt     <= 2'h0;
      active_rate <= eff_rate;
      active_src  <= clock_control[CLK_SRC_BIT];
      active_en   <= clock_control[CLK_EN_BIT];
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // pll model: core ticks per master cycle = (R + N/M) / (4 (X + 1)) in fractional mode, R / (4 (X + 1)) in integer mode; saturates at one per cycle
  logic [23:0] nco_acc;
  logic [23:0] nco_num;
  logic [23:0] nco_den;
  logic [23:0] nco_sum;
  logic [23:0] x_div;
  logic        frac_mode;
  logic        nco_tick;
  logic        raw_tick;
  assign frac_mode = pll_settings[PLL_FRAC_BIT] && (pll_settings[PLL_M_LSB +: 16] != 16'h0);
  assign x_div     = {22'h0, pll_settings[PLL_X_LSB +: 2]} + 24'h1;
  assign nco_num   = frac_mode ? ({20'h0, pll_settings[PLL_R_LSB +: 4]} * {8'h0, pll_settings[PLL_M_LSB +: 16]}
                                  + {8'h0, pll_settings[PLL_N_LSB +: 16]})
                               : {20'h0, pll_settings[PLL_R_LSB +: 4]};
  assign nco_den   = (frac_mode ? {8'h0, pll_settings[PLL_M_LSB +: 16]} : 24'h1) * x_div * CORE_DIV_PLL;
  assign nco_sum   = nco_acc + nco_num;
  assign nco_tick  = (nco_num >= nco_den) || (nco_sum >= nco_den);
  always_ff @(posedge clk_i) begin
    if (run_rst || !pll_locked || (nco_num >= nco_den)) begin
      nco_acc <= 24'h0;
    end else if (nco_sum >= nco_den) begin
      nco_acc <= nco_sum - nco_den;
    end else begin
      nco_acc <= nco_sum;
    end
  end
  assign raw_tick = active_en && (active_src ? (pll_locked && nco_tick) : (div_cnt == active_rate));

  logic [11:0] fs_cnt [3];
  logic [3:0]  fs_code [3];
  logic [2:0]  fs_run;
  logic [2:0]  fs_q;
  assign fs_code[0] = {1'b0, converter_control_zero[2:0]};
  assign fs_code[1] = {1'b0, serial_port_rate[2:0]};
  assign fs_code[2] = engine_frame_rate[3:0];
  assign fs_run     = {digital_power_enable_zero[PWR0_ENGINE_BIT], 1'b1,
                       digital_power_enable_one[PWR1_ADC_BIT] | digital_power_enable_one[PWR1_DAC_BIT]};
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (run_rst) begin
        fs_cnt[i] <= 12'h0;
        fs_q[i]   <= 1'b0;
      end else begin
        fs_q[i] <= 1'b0;
        if (raw_tick && fs_run[i]) begin
          if (fs_cnt[i] >= rate_period(fs_code[i]) - 12'h1) begin
            fs_cnt[i] <= 12'h0;
            fs_q[i]   <= 1'b1;
          end else begin
            fs_cnt[i] <= fs_cnt[i] + 12'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (run_rst) begin
      core_tick_o <= 1'b0;
    end else begin
      core_tick_o <= raw_tick;
    end
  end
  assign conv_fs_o      = fs_q[0];
  assign serial_fs_o    = fs_q[1];
  assign engine_fs_o    = fs_q[2];
  assign adc_osr64_o    = converter_control_zero[CONV_ADC_OSR];
  assign dac_osr64_o    = converter_control_zero[CONV_DAC_OSR];
  assign adc_on_o       = digital_power_enable_one[PWR1_ADC_BIT];
  assign dac_on_o       = digital_power_enable_one[PWR1_DAC_BIT];
  assign pll_on_o       = pll_settings[PLL_EN_BIT];
  assign pll_locked_o   = pll_locked;
  assign memctl_on_o    = digital_power_enable_zero[PWR0_MEMCTL_BIT];
  assign engine_on_o    = digital_power_enable_zero[PWR0_ENGINE_BIT];
  assign powered_down_o = pdn_sync;
endmodule
`default_nettype wire

/* File: ccpc_host.sv */
`default_nettype none
module ccpc_host
  import ccpc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  ccpc_cp_if.host          cp,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic        cmd_write_i,
  input  wire logic        cmd_pll_i,
  input  wire logic [15:0] cmd_addr_i,
  input  wire logic [7:0]  cmd_wdata_i,
  input  wire logic [47:0] pll_bytes_i,
  input  wire logic        power_down_i,
  output logic             rsp_valid_o,
  output logic [7:0]       rsp_rdata_o,
  output logic             rsp_err_o
);
  ccpc_host_state_t state;
  logic [47:0] pll_buf;
  logic [2:0]  byte_idx;
  logic        en_seen;
  logic        src_seen;
  logic        lock_seen;
  logic        pwr_seen;
  logic        take;
  logic        is_setup;
  logic        local_refuse;
  logic [7:0]  fixed_wdata;
  logic [2:0]  next_idx;

  assign take     = cmd_valid_i && cmd_ready_o;
  assign next_idx = byte_idx + 3'h1;
  assign is_setup = (cmd_addr_i == CLOCK_CONTROL_ADDR) ||
                    ((cmd_addr_i >= PLL_SETTINGS_ADDR) && (cmd_addr_i <= PLL_LAST_ADDR));
  always_comb begin
    local_refuse = cp.power_down_pin_n;
    if (!is_setup && !(en_seen && (!src_seen || lock_seen))) begin
      local_refuse = 1'b1;
    end
    if (((cmd_addr_i == ENGINE_RATE_ADDR) || (cmd_addr_i == SERIAL_RATE_ADDR)) && !pwr_seen) begin
      local_refuse = 1'b1;
    end
  end
  // with the pll selected the rate field must say 1024 fs
  always_comb begin
    fixed_wdata = cmd_wdata_i;
    if ((cmd_addr_i == CLOCK_CONTROL_ADDR) && cmd_wdata_i[CLK_SRC_BIT]) begin
      fixed_wdata[CLK_RATE_LSB +: 2] = RATE_1024FS;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cp.power_down_pin_n <= 1'b0;
    end else begin
      cp.power_down_pin_n <= power_down_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || cp.power_down_pin_n) begin
      state       <= HS_IDLE;
      cp.valid    <= 1'b0;
      cp.write    <= 1'b0;
      cp.burst    <= 1'b0;
      cp.addr     <= 16'h0;
      cp.wdata    <= 8'h00;
      pll_buf     <= 48'h0;
      byte_idx    <= 3'h0;
      cmd_ready_o <= rst_n_i;
      rsp_valid_o <= rst_n_i && take;
      rsp_rdata_o <= 8'h00;
      rsp_err_o   <= rst_n_i && take;
    end else begin
      rsp_valid_o <= 1'b0;
      unique case (state)
        HS_IDLE: begin
          cmd_ready_o <= 1'b1;
          if (take && cmd_pll_i) begin
            pll_buf     <= pll_bytes_i;
            byte_idx    <= 3'h0;
            cp.valid    <= 1'b1;
            cp.write    <= 1'b1;
            cp.burst    <= 1'b1;
            cp.addr     <= PLL_SETTINGS_ADDR;
            cp.wdata    <= pll_bytes_i[7:0];
            cmd_ready_o <= 1'b0;
            state       <= HS_BURST;
          end else if (take && local_refuse) begin
            rsp_valid_o <= 1'b1;
            rsp_rdata_o <= 8'h00;
            rsp_err_o   <= 1'b1;
          end else if (take) begin
            cp.valid    <= 1'b1;
            cp.write    <= cmd_write_i;
            cp.burst    <= 1'b0;
            cp.addr     <= cmd_addr_i;
            cp.wdata    <= fixed_wdata;
            cmd_ready_o <= 1'b0;
            state       <= HS_SINGLE;
          end
        end
        HS_SINGLE: begin
          if (cp.ack) begin
            cp.valid    <= 1'b0;
            rsp_valid_o <= 1'b1;
            rsp_rdata_o <= cp.rdata;
            rsp_err_o   <= cp.err;
            cmd_ready_o <= 1'b1;
            state       <= HS_IDLE;
          end
        end
        HS_BURST: begin
          if (cp.ack) begin
            if (byte_idx == PLL_LAST_IDX) begin
              cp.valid    <= 1'b0;
              cp.burst    <= 1'b0;
              rsp_valid_o <= 1'b1;
              rsp_rdata_o <= 8'h00;
              rsp_err_o   <= cp.err;
              cmd_ready_o <= 1'b1;
              state       <= HS_IDLE;
            end else begin
              byte_idx <= next_idx;
              cp.addr  <= cp.addr + 16'h1;
              cp.wdata <= pll_buf[{next_idx, 3'b000} +: 8];
            end
          end
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  // shadows of what the device was told; a new pll burst means relock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || cp.power_down_pin_n) begin
      en_seen   <= 1'b0;
      src_seen  <= 1'b0;
      lock_seen <= 1'b0;
      pwr_seen  <= 1'b0;
    end else if (cp.ack && !cp.err) begin
      if (state == HS_BURST) begin
        lock_seen <= 1'b0;
      end else if (cp.write && (cp.addr == CLOCK_CONTROL_ADDR)) begin
        en_seen  <= cp.wdata[CLK_EN_BIT];
        src_seen <= cp.wdata[CLK_SRC_BIT];
      end else if (cp.write && (cp.addr == POWER_ZERO_ADDR)) begin
        pwr_seen <= cp.wdata[PWR0_MEMCTL_BIT] && cp.wdata[PWR0_ENGINE_BIT];
      end else if (!cp.write && (cp.addr == PLL_LAST_ADDR)) begin
        lock_seen <= cp.rdata[PLL_LOCK_BIT - PLL_TOP_LSB];
      end
    end
  end
endmodule
`default_nettype wire

/* File: ccpc_cp_checker.sv */
`default_nettype none
module ccpc_cp_checker
  import ccpc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        valid,
  input wire logic        write,
  input wire logic        burst,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        ack,
  input wire logic [7:0]  rdata,
  input wire logic        err,
  input wire logic        power_down_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  // the device sits in reset while the pin is high, so port timing is void then
  default disable iff (!rst_n_i || power_down_pin_n);
  sequence req_s;
    valid && !ack;
  endsequence
  sequence ans_s;
    ack ##1 !ack;
  endsequence
  ack_latency_a: assert property (req_s |=> ans_s)
    else $error("request not answered with one ack pulse");
  req_hold_a: assert property (req_s |=> valid && $stable(addr) && $stable(write) && $stable(wdata))
    else $error("request changed before its ack");
  ack_cause_a: assert property (ack |-> $past(valid) && !$past(ack))
    else $error("ack without a pending request");
  err_refuse_a: assert property (err |-> ack && rdata == 8'h00)
    else $error("refusal without ack or with data");
  write_rdata_a: assert property (ack && $past(write) |-> rdata == 8'h00)
    else $error("write answered with data");
  burst_range_a: assert property (burst && valid |-> write && addr >= PLL_SETTINGS_ADDR && addr <= PLL_LAST_ADDR)
    else $error("burst outside the pll bytes");
  burst_order_a: assert property (burst && ack && addr != PLL_LAST_ADDR |=> valid && burst && addr == $past(addr) + 16'h1)
    else $error("pll burst broken or out of order");
  pd_quiet_a: assert property (disable iff (!rst_n_i) power_down_pin_n [*5] |-> !ack)
    else $error("ack while powered down");
endmodule
`default_nettype wire

/* File: codec_clock_power_control_tb.sv */
`default_nettype none
module codec_clock_power_control_tb
  import ccpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_n_i, cmd_valid_i, cmd_ready_o, cmd_write_i, cmd_pll_i, power_down_i;
  logic [15:0] cmd_addr_i;
  logic [7:0]  cmd_wdata_i, rsp_rdata_o;
  logic [47:0] pll_bytes_i;
  logic        rsp_valid_o, rsp_err_o, core_tick_o, conv_fs_o, serial_fs_o, engine_fs_o;
  logic        adc_osr64_o, dac_osr64_o, adc_on_o, dac_on_o, pll_on_o, pll_locked_o;
  logic        memctl_on_o, engine_on_o, powered_down_o;
  logic [3:0]  taps;
  logic [8:0]  exp_q[$];
  logic [31:0] rnd;
  int          error_cnt, n_checks;
  int          per_t[7] = '{256, 1536, 1024, 768, 512, 384, 128};
  assign taps = {engine_fs_o, serial_fs_o, conv_fs_o, core_tick_o};
  always #4 clk_i = ~clk_i;
  ccpc_cp_if cp_if ();
  // short lock count keeps the pll scenario inside the run budget
  ccpc_device #(.LOCK_CYCLES_P(20)) ccpc_device_i (.clk_i, .rst_n_i, .cp(cp_if.device), .core_tick_o,
    .conv_fs_o, .serial_fs_o, .engine_fs_o, .adc_osr64_o, .dac_osr64_o, .adc_on_o, .dac_on_o,
    .pll_on_o, .pll_locked_o, .memctl_on_o, .engine_on_o, .powered_down_o);
  ccpc_host ccpc_host_i (.clk_i, .rst_n_i, .cp(cp_if.host), .cmd_valid_i, .cmd_ready_o, .cmd_write_i,
    .cmd_pll_i, .cmd_addr_i, .cmd_wdata_i, .pll_bytes_i, .power_down_i, .rsp_valid_o, .rsp_rdata_o,
    .rsp_err_o);
  ccpc_cp_checker ccpc_cp_checker_i (.clk_i, .rst_n_i, .valid(cp_if.valid), .write(cp_if.write),
    .burst(cp_if.burst), .addr(cp_if.addr), .wdata(cp_if.wdata), .ack(cp_if.ack), .rdata(cp_if.rdata),
    .err(cp_if.err), .power_down_pin_n(cp_if.power_down_pin_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task results;
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // e holds {err, rdata}; the monitor pops it when the response shows
  task cmd(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [8:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    cmd_write_i = w;
    cmd_addr_i = a;
    cmd_wdata_i = d;
    cmd_valid_i = 1'b1;
    do begin @(posedge clk_i); n++; end while (cmd_ready_o !== 1'b1 && n < 100);
    #1;
    cmd_valid_i = 1'b0;
    cmd_pll_i = 1'b0;
    do begin @(posedge clk_i); n++; end while (exp_q.size() != 0 && n < 300);
    #1;
    chk(exp_q.size(), 32'h0);
  endtask
  // third interval only: a new setting lands at the divider wrap
  task per(input int s, input int exp);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin @(posedge clk_i); n++; end while (taps[s] !== 1'b1 && n < 2000);
    end
    chk(n, exp);
    #1;
  endtask
  always @(posedge clk_i) begin
    if (rst_n_i === 1'b1 && rsp_valid_o === 1'b1) begin
      if (exp_q.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk({rsp_err_o, rsp_rdata_o}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    results;
  end
  initial begin
    {rst_n_i, cmd_valid_i, cmd_write_i, cmd_pll_i, power_down_i} = 5'h0;
    cmd_addr_i = 16'h0;
    cmd_wdata_i = 8'h0;
    pll_bytes_i = 48'h0;
    rnd = 32'hD7AB;
    tick(20);
    rst_n_i = 1'b1;
    tick(2);
    cmd(1'h0, CLOCK_CONTROL_ADDR, 8'h00, 9'h000);
    cmd(1'h0, CONV_CONTROL_ADDR, 8'h00, 9'h100);
    chk(core_tick_o, 1'h0);
    cmd(1'h1, CLOCK_CONTROL_ADDR, 8'h01, 9'h000);
    cmd(1'h0, 16'h4001, 8'h00, 9'h000);
    chk({adc_osr64_o, engine_on_o}, 2'h0);
    for (int c = 0; c < 4; c++) begin
      cmd(1'h1, CLOCK_CONTROL_ADDR, 8'(c * 2 + 1), 9'h000);
      cmd(1'h0, CLOCK_CONTROL_ADDR, 8'h00, 9'(c * 2 + 1));
      per(0, c + 1);
    end
    cmd(1'h1, CLOCK_CONTROL_ADDR, 8'h01, 9'h000);
    cmd(1'h1, ENGINE_RATE_ADDR, 8'h00, 9'h100);
    cmd(1'h1, POWER_ZERO_ADDR, 8'h41, 9'h000);
    chk({memctl_on_o, engine_on_o}, 2'h3);
    cmd(1'h1, POWER_ONE_ADDR, 8'h03, 9'h000);
    chk({adc_on_o, dac_on_o}, 2'h3);
    for (int c = 0; c < 7; c++) begin
      cmd(1'h1, CONV_CONTROL_ADDR, 8'(c) | 8'h30, 9'h000);
      per(1, per_t[c]);
    end
    chk({adc_osr64_o, dac_osr64_o}, 2'h3);
    cmd(1'h1, POWER_ONE_ADDR, 8'h00, 9'h000);
    chk({adc_on_o, dac_on_o}, 2'h0);
    rnd = lfsr(rnd);
    cmd(1'h1, ENGINE_RATE_ADDR, 8'(rnd % 7), 9'h000);
    cmd(1'h0, ENGINE_RATE_ADDR, 8'h00, 9'(rnd % 7));
    per(3, per_t[rnd % 7]);
    rnd = lfsr(rnd);
    cmd(1'h1, SERIAL_RATE_ADDR, rnd[7:0], 9'h000);
    cmd(1'h0, SERIAL_RATE_ADDR, 8'h00, {1'h0, rnd[7:0] & SERIAL_RATE_MASK});
    // unused serial code 7 falls back to the base rate
    per(2, (rnd[2:0] == 3'h7) ? 256 : per_t[rnd[2:0]]);
    // integer mode suits the reference this bench supplies
    pll_bytes_i = (48'h2 << PLL_R_LSB) | (48'h1 << PLL_EN_BIT);
    cmd_pll_i = 1'b1;
    cmd(1'h1, PLL_SETTINGS_ADDR, 8'h00, 9'h000);
    chk(pll_on_o, 1'h1);
    cmd(1'h1, CLOCK_CONTROL_ADDR, 8'h09, 9'h000);
    tick(40);
    cmd(1'h0, PLL_LAST_ADDR, 8'h00, 9'h003);
    cmd(1'h0, CLOCK_CONTROL_ADDR, 8'h00, 9'h00F);
    per(0, 2);
    chk(pll_locked_o, 1'h1);
    power_down_i = 1'b1;
    tick(6);
    chk({powered_down_o, memctl_on_o, pll_on_o}, 3'h4);
    cmd(1'h0, CLOCK_CONTROL_ADDR, 8'h00, 9'h100);
    power_down_i = 1'b0;
    tick(6);
    cmd(1'h0, CLOCK_CONTROL_ADDR, 8'h00, 9'h000);
    cmd(1'h0, POWER_ZERO_ADDR, 8'h00, 9'h100);
    results;
  end
endmodule
`default_nettype wire
